//--- rtl/berh_ctrl.v
// bus exception, restart, halt, float and queue status control
`timescale 1ns/100ps
`include "berh_consts.vh"

// Functional notes
// - fault before transfer acknowledge passes two sync stages before use.
// - fault after transfer acknowledge is sampled through one stage.
// - fault is ignored while data bus shadow is active.
// - restart ack asserts on external request or internal reset.
// - reset routine starts only after restart ack is released.
// - restart request must stand three cycles; shorter requests ignored.
// - restart ack asserts immediately once request qualifies.
// - redo request ends transaction, reissues it after release.
// - yield-redo ends transaction and floats the bus outputs.
// - yield-redo ack asserts after the bus is floated.
// - yield-redo ack releases when preempted transaction is reissued.
// - arbitration inputs ignored while yield-redo request active.
// - preempted transaction reissued when yield-redo request releases.
// - halt request stops new instructions; three more may complete.
// - float input puts every output pin into high impedance.
// - queue code 00 four, 01 one, 10 two, 11 no discard.
// - opcode_taken pulses when control takes next opcode from queue.
// - read data latched, transaction ends one cycle after ack low.
module berh_ctrl #(
   parameter DATA_W = 32
) (
   // clocking
   input  wire              clock,
   input  wire              reset_n,
   input  wire              clock_en,
   // pins from outside, active low except data_in
   input  wire              transfer_ack_n,
   input  wire              sync_go_n,
   input  wire              fault_n,
   input  wire              redo_n,
   input  wire              yield_redo_request_n,
   input  wire              data_bus_shadow_n,
   input  wire              restart_request_n,
   input  wire              halt_request_n,
   input  wire              float_all_outputs_n,
   input  wire              arb_request_n,
   input  wire [DATA_W-1:0] data_in,
   // core side, same clock
   input  wire              core_start,
   input  wire              core_read,
   input  wire              core_internal_reset,
   input  wire              core_reset_done,
   input  wire              core_instr_done,
   input  wire              core_opcode_fetch,
   input  wire [1:0]        core_discard_code,
   // core side results
   output reg               xfer_done,
   output reg               xfer_fault,
   output reg  [DATA_W-1:0] read_data,
   output reg               reset_routine_go,
   output reg               halted,
   output reg               arb_request_seen,
   // bus control outputs, active low, with enables
   output reg               address_strobe_n,
   output reg               data_strobe_n,
   output reg               transaction_begin_n,
   output reg               data_ready_out_n,
   output reg               bus_ctrl_oe,
   output reg               data_side_oe,
   // status outputs
   output reg               restart_ack_n,
   output reg               yield_redo_ack_n,
   output reg               opcode_taken_n,
   output reg  [1:0]        queue_discard_code,
   output reg               status_oe
);
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   wire [6:0] sync_q;
   reg        fault_one;
   reg  [DATA_W-1:0] data_hold;

   berh_sync #(
      .WIDTH (7),
      .INIT  (7'h7f)
   ) u_sync (
      .clock    (clock),
      .reset_n  (reset_n),
      .clock_en (clock_en),
      .d        ({transfer_ack_n, fault_n, redo_n, yield_redo_request_n,
                  restart_request_n, halt_request_n, arb_request_n}),
      .q        (sync_q)
   );

   wire ack_s   = ~sync_q[6];
   wire fault_2 = ~sync_q[5];
   wire redo_s  = ~sync_q[4];
   wire yield_s = ~sync_q[3];
   wire rst_s   = ~sync_q[2];
   wire halt_s  = ~sync_q[1];
   wire arb_s   = ~sync_q[0];

   // shadow and float bypass the synchronisers, registered once into the enables
   wire shadow = ~data_bus_shadow_n;
   wire hz     = ~float_all_outputs_n;
   wire go_s   = ~sync_go_n;

   // ------------------------------------------------------------
   // transaction state machine
   // ------------------------------------------------------------
   localparam [5:0] S_IDLE  = 6'h01;
   localparam [5:0] S_WAIT  = 6'h02;
   localparam [5:0] S_END   = 6'h04;
   localparam [5:0] S_REDO  = 6'h08;
   localparam [5:0] S_YIELD = 6'h10;
   localparam [5:0] S_FLOAT = 6'h20;

   reg [5:0] state;
   reg [5:0] next_state;
   reg       acked;
   reg       is_read;
   reg       ended_fault;
   reg [3:0] rst_state;
   wire      rst_cnt_ok;

   // single-latched fault once ack is seen
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fault_one     <= 1'b0;
      end else if (clock_en) begin
         fault_one     <= ~fault_n;
      end
   end

   wire fault_seen = shadow ? 1'b0 :
                     (acked ? fault_one : fault_2);
   wire term_ok    = ~shadow & (ack_s | go_s);

   always @* begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (core_start && rst_cnt_ok == 1'b0 && !halted)
               next_state = S_WAIT;
         end
         S_WAIT: begin
            if (yield_s)
               next_state = S_YIELD;
            else if (redo_s)
               next_state = S_REDO;
            else if (fault_seen || term_ok)
               next_state = S_END;
         end
         S_END: begin
            next_state = S_IDLE;
         end
         S_REDO: begin
            if (!redo_s)
               next_state = S_WAIT;
         end
         S_YIELD: begin
            next_state = S_FLOAT;
         end
         S_FLOAT: begin
            if (!yield_s)
               next_state = S_WAIT;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // restart request qualification and acknowledge
   // ------------------------------------------------------------
   localparam [3:0] R_RUN  = 4'h1;
   localparam [3:0] R_ACK  = 4'h2;
   localparam [3:0] R_WREL = 4'h4;
   localparam [3:0] R_GO   = 4'h8;

   reg [1:0] rst_cnt;
   reg [3:0] ack_hold;

   assign rst_cnt_ok = (rst_state != R_RUN);

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_state        <= R_RUN;
         rst_cnt          <= 2'd0;
         ack_hold         <= 4'd0;
         restart_ack_n    <= 1'b1;
         reset_routine_go <= 1'b0;
      end else if (clock_en) begin
         reset_routine_go <= 1'b0;
         if (rst_s && rst_cnt != `BERH_RST_MIN_CYC)
            rst_cnt <= rst_cnt + 2'd1;
         else if (!rst_s)
            rst_cnt <= 2'd0;
         case (rst_state)
            R_RUN: begin
               if ((rst_s && rst_cnt == `BERH_RST_MIN_CYC - 2'd1) ||
                   core_internal_reset) begin
                  restart_ack_n <= 1'b0;
                  ack_hold      <= `BERH_ACK_HOLD_CYC;
                  rst_state     <= R_ACK;
               end
            end
            R_ACK: begin
               if (ack_hold != 4'd0)
                  ack_hold <= ack_hold - 4'd1;
               else if (!rst_s)
                  rst_state <= R_WREL;
            end
            R_WREL: begin
               restart_ack_n <= 1'b1;
               rst_state     <= R_GO;
            end
            R_GO: begin
               reset_routine_go <= restart_ack_n;
               if (restart_ack_n && core_reset_done)
                  rst_state <= R_RUN;
            end
            default: begin
               rst_state <= R_RUN;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // transaction registers and outputs
   // ------------------------------------------------------------
   reg [1:0] slip;
   reg       float_bus;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state               <= S_IDLE;
         acked               <= 1'b0;
         is_read             <= 1'b0;
         ended_fault         <= 1'b0;
         float_bus           <= 1'b0;
         xfer_done           <= 1'b0;
         xfer_fault          <= 1'b0;
         read_data           <= {DATA_W{1'b0}};
         data_hold           <= {DATA_W{1'b0}};
         address_strobe_n    <= 1'b1;
         data_strobe_n       <= 1'b1;
         transaction_begin_n <= 1'b1;
         data_ready_out_n    <= 1'b1;
         yield_redo_ack_n    <= 1'b1;
         arb_request_seen    <= 1'b0;
      end else if (clock_en) begin
         state               <= next_state;
         xfer_done           <= 1'b0;
         xfer_fault          <= 1'b0;
         data_ready_out_n    <= 1'b1;
         transaction_begin_n <= ~(next_state == S_WAIT &&
                                  state != S_WAIT);
         address_strobe_n    <= ~(next_state == S_WAIT);
         data_strobe_n       <= ~(next_state == S_WAIT);
         arb_request_seen    <= arb_s & ~yield_s;
         if (state == S_IDLE && core_start)
            is_read <= core_read;
         if (state == S_WAIT && ack_s)
            acked <= 1'b1;
         if (next_state == S_END) begin
            ended_fault <= fault_seen;
            data_hold   <= data_in;
         end
         if (state == S_END) begin
            acked            <= 1'b0;
            xfer_done        <= 1'b1;
            xfer_fault       <= ended_fault;
            data_ready_out_n <= ended_fault;
            if (is_read)
               read_data <= data_hold;
         end
         if (state == S_REDO || state == S_YIELD)
            acked <= 1'b0;
         if (next_state == S_YIELD)
            float_bus <= 1'b1;
         else if (next_state == S_WAIT)
            float_bus <= 1'b0;
         if (state == S_YIELD)
            yield_redo_ack_n <= 1'b0;
         else if (state == S_FLOAT && next_state == S_WAIT)
            yield_redo_ack_n <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // halt, queue status, opcode taken, output enables
   // ------------------------------------------------------------
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         slip               <= 2'd0;
         halted             <= 1'b0;
         opcode_taken_n     <= 1'b1;
         queue_discard_code <= `BERH_IQ_NONE;
         bus_ctrl_oe        <= 1'b0;
         data_side_oe       <= 1'b0;
         status_oe          <= 1'b0;
      end else if (clock_en) begin
         if (!halt_s) begin
            slip   <= 2'd0;
            halted <= 1'b0;
         end else if (core_instr_done && !halted) begin
            if (slip == `BERH_HALT_SLIP)
               halted <= 1'b1;
            else
               slip <= slip + 2'd1;
         end
         opcode_taken_n     <= ~(core_opcode_fetch & ~halted);
         queue_discard_code <= core_discard_code;
         bus_ctrl_oe        <= ~hz & ~(next_state == S_YIELD ||
                                       next_state == S_FLOAT);
         data_side_oe       <= ~hz & ~shadow & ~(next_state == S_YIELD ||
                                       next_state == S_FLOAT) &
                               ~is_read;
         status_oe          <= ~hz;
      end
   end
endmodule

//--- rtl/berh_consts.vh
// timing counts and codes for the bus exception, reset and halt control
`ifndef BERH_CONSTS_VH
`define BERH_CONSTS_VH
`define BERH_RST_MIN_CYC     2'd3
`define BERH_HALT_SLIP       2'd2
`define BERH_IQ_DISC4        2'h0
`define BERH_IQ_DISC1        2'h1
`define BERH_IQ_DISC2        2'h2
`define BERH_IQ_NONE         2'h3
`define BERH_ACK_HOLD_CYC    4'd8
`endif

//--- rtl/berh_sync.v
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module berh_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   // clocking
   input  wire             clock,
   input  wire             reset_n,
   input  wire             clock_en,
   // data
   input  wire [WIDTH-1:0] d,
   output reg  [WIDTH-1:0] q
);
   reg [WIDTH-1:0] stage1;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= INIT;
         q      <= INIT;
      end else if (clock_en) begin
         stage1 <= d;
         q      <= stage1;
      end
   end
endmodule

//--- tb/berh_ctrl_properties.sv
// port assertions for the bus exception, restart and halt control
`timescale 1ns/100ps
module berh_ctrl_properties (
   // clocking and inputs
   input wire       clock, reset_n, float_all_outputs_n,
   input wire       data_bus_shadow_n, core_opcode_fetch,
   input wire [1:0] core_discard_code,
   // outputs of the block
   input wire       xfer_done, xfer_fault, reset_routine_go,
   input wire       arb_request_seen, address_strobe_n, data_ready_out_n,
   input wire       bus_ctrl_oe, data_side_oe, restart_ack_n, status_oe,
   input wire       yield_redo_ack_n, opcode_taken_n,
   input wire [1:0] queue_discard_code
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_float;
      !float_all_outputs_n [*2] |-> !(bus_ctrl_oe|data_side_oe|status_oe);
   endproperty
   a_float: assert property (p_float) else $error("driven in float");
   property p_shad;
      !data_bus_shadow_n [*2] |-> !data_side_oe;
   endproperty
   a_shad: assert property (p_shad) else $error("data side driven");
   property p_yack;
      $fell(yield_redo_ack_n) |-> !bus_ctrl_oe && !$past(bus_ctrl_oe);
   endproperty
   a_yack: assert property (p_yack) else $error("ack before float");
   property p_arb;
      !yield_redo_ack_n |-> !$rose(arb_request_seen);
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration seen");
   property p_rhold;
      $fell(restart_ack_n) |=> !restart_ack_n [*7];
   endproperty
   a_rhold: assert property (p_rhold) else $error("restart ack short");
   property p_rgo;
      reset_routine_go |-> restart_ack_n && $past(restart_ack_n);
   endproperty
   a_rgo: assert property (p_rgo) else $error("routine before release");
   property p_queue;
      queue_discard_code == $past(core_discard_code);
   endproperty
   a_queue: assert property (p_queue) else $error("queue code wrong");
   property p_opc;
      !opcode_taken_n |-> $past(core_opcode_fetch);
   endproperty
   a_opc: assert property (p_opc) else $error("stray opcode pulse");
   property p_data_ready_out;
      !data_ready_out_n |-> xfer_done && !xfer_fault &&
                            !$past(address_strobe_n, 2);
   endproperty
   a_data_ready_out: assert property (p_data_ready_out) else $error("bad data ready");
endmodule
bind berh_ctrl berh_ctrl_properties berh_ctrl_properties_i (
   .clock, .reset_n, .float_all_outputs_n, .data_bus_shadow_n,
   .core_opcode_fetch, .core_discard_code, .xfer_done, .xfer_fault,
   .reset_routine_go, .arb_request_seen, .address_strobe_n,
   .data_ready_out_n, .bus_ctrl_oe, .data_side_oe, .restart_ack_n,
   .status_oe, .yield_redo_ack_n, .opcode_taken_n, .queue_discard_code);

//--- tb/berh_slave_model.sv
// slave device answering reads after a set number of waits
`timescale 1ns/100ps
module berh_slave_model (
   // clock and bus from the block
   input  wire        clock, address_strobe_n, bus_ctrl_oe,
   // bench controls
   input  wire [3:0]  wait_cycles,
   input  wire [31:0] read_word,
   // answers
   output reg         transfer_ack_n,
   output reg  [31:0] data_in
);
   reg [3:0] cnt;
   initial begin
      transfer_ack_n = 1'b1;
      data_in = 32'h0;
      cnt = 4'h0;
   end
   always @(posedge clock) begin
      if (address_strobe_n || !bus_ctrl_oe) begin
         cnt <= 4'h0;
         transfer_ack_n <= 1'b1;
         data_in <= ~data_in;
      end else if (cnt == wait_cycles) begin
         transfer_ack_n <= 1'b0;
         data_in <= read_word;
      end else begin
         cnt <= cnt + 4'h1;
         data_in <= ~data_in;
      end
   end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the bus exception, restart and halt control
`timescale 1ns/100ps
module tb_top;
   reg         clock, reset_n, fault_n, redo_n, yr_n, shad_n, rreq_n, flt_n;
   reg         arb_n, start, fetch, halt_n, idone;
   reg  [1:0]  disc;
   reg  [3:0]  wait_c;
   reg  [31:0] word_v;
   wire        ack_n, done, xflt, go, hlt, arb_seen, astb_n, beg_n, rdy_n;
   wire        bus_oe, dat_oe, rack_n, yack_n, opc_n, st_oe;
   wire [1:0]  qcode;
   wire [31:0] din, rdata;
   integer     fail_count, samples_checked, cyc, nbeg, i, j;
   berh_ctrl berh_ctrl_i (
      .clock(clock), .reset_n(reset_n), .clock_en(1'b1),
      .transfer_ack_n(ack_n), .sync_go_n(1'b1), .fault_n(fault_n),
      .redo_n(redo_n), .yield_redo_request_n(yr_n),
      .data_bus_shadow_n(shad_n), .restart_request_n(rreq_n),
      .halt_request_n(halt_n), .float_all_outputs_n(flt_n),
      .arb_request_n(arb_n), .data_in(din), .core_start(start),
      .core_read(1'b1), .core_internal_reset(1'b0), .core_reset_done(1'b0),
      .core_instr_done(idone), .core_opcode_fetch(fetch),
      .core_discard_code(disc), .xfer_done(done), .xfer_fault(xflt),
      .read_data(rdata), .reset_routine_go(go), .halted(hlt),
      .arb_request_seen(arb_seen), .address_strobe_n(astb_n),
      .data_strobe_n(), .transaction_begin_n(beg_n),
      .data_ready_out_n(rdy_n), .bus_ctrl_oe(bus_oe), .data_side_oe(dat_oe),
      .restart_ack_n(rack_n), .yield_redo_ack_n(yack_n),
      .opcode_taken_n(opc_n), .queue_discard_code(qcode), .status_oe(st_oe));
   berh_slave_model slave_i (.clock(clock), .address_strobe_n(astb_n),
      .bus_ctrl_oe(bus_oe), .wait_cycles(wait_c), .read_word(word_v),
      .transfer_ack_n(ack_n), .data_in(din));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (!beg_n) nbeg = nbeg + 1;
      if (cyc == 3000) begin
         fail_count = fail_count + 1;
         close_out;
      end
   end
   task tick;
      @(posedge clock) #1;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: %h %h", $time, got, exp);
         end
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task txn(input [3:0] w, input [31:0] d, input bad);
      begin
         wait_c = w;
         word_v = d;
         start = 1'b1;
         tick;
         start = 1'b0;
         for (i = 0; i < 60 && done !== 1'b1; i = i + 1) tick;
         chk({done, xflt, rdy_n}, {1'b1, bad, bad});
         if (!bad) chk(rdata, d);
         repeat(2) tick;
      end
   endtask
   task s_read;
      begin
         txn(4'h0, 32'h1234_5678, 1'b0);
         txn(4'h3, 32'hcafe_0042, 1'b0);
         $display("read test done");
      end
   endtask
   task s_fault(input sh);
      begin
         fork
            txn(4'hc, 32'h0f0f_a5a5, !sh);
            begin
               repeat(3) tick;
               shad_n = !sh;
               fault_n = 1'b0;
               repeat(3) tick;
               fault_n = 1'b1;
               repeat(3) tick;
               shad_n = 1'b1;
            end
         join
         $display("fault test done");
      end
   endtask
   task s_retry(input yl);
      begin
         nbeg = 0;
         fork
            txn(4'ha, 32'h2468_ace0, 1'b0);
            begin
               repeat(3) tick;
               {yr_n, arb_n, redo_n} = {!yl, !yl, yl};
               for (j = 0; j < 8 && yack_n !== 1'b0; j = j + 1) tick;
               repeat(2) tick;
               chk({yack_n, yl & (bus_oe | dat_oe), arb_seen}, {!yl, 2'h0});
               {yr_n, arb_n, redo_n} = 3'h7;
            end
         join
         chk(nbeg, 32'h2);
         chk(yack_n, 1'b1);
         $display("retry test done");
      end
   endtask
   task s_restart;
      begin
         rreq_n = 1'b0;
         repeat(2) tick;
         rreq_n = 1'b1;
         for (i = 0; i < 12 && rack_n === 1'b1; i = i + 1) tick;
         chk(rack_n, 1'b1);
         rreq_n = 1'b0;
         for (i = 0; i < 8 && rack_n !== 1'b0; i = i + 1) tick;
         chk(rack_n, 1'b0);
         rreq_n = 1'b1;
         for (i = 0; i < 30 && go !== 1'b1; i = i + 1) tick;
         chk({go, rack_n}, 2'h3);
         $display("restart test done");
      end
   endtask
   task s_status;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            disc = i[1:0];
            tick;
            chk(qcode, disc);
         end
         fetch = 1'b1;
         tick;
         fetch = 1'b0;
         chk(opc_n, 1'b0);
         flt_n = 1'b0;
         repeat(2) tick;
         chk({bus_oe, dat_oe, st_oe, opc_n}, 4'h1);
         flt_n = 1'b1;
         halt_n = 1'b0;
         repeat(3) begin
            repeat(3) tick;
            chk(hlt, 1'b0);
            idone = 1'b1;
            tick;
            idone = 1'b0;
         end
         tick;
         chk(hlt, 1'b1);
         $display("status test done");
      end
   endtask
   initial begin
      {reset_n, start, fetch, idone} = 4'h0;
      {fault_n, redo_n, yr_n, shad_n, rreq_n, flt_n, arb_n, halt_n} = 8'hff;
      {disc, wait_c, word_v} = 38'h30_0000_0000;
      {fail_count, samples_checked, cyc, nbeg} = 128'h0;
      repeat(4) @(posedge clock);
      #1 reset_n = 1'b1;
      tick;
      s_read;
      s_fault(1'b1);
      s_fault(1'b0);
      s_retry(1'b0);
      s_retry(1'b1);
      s_restart;
      s_status;
      close_out;
   end
endmodule
